//--- smbm_chk.sv
`timescale 1ns/1ps
module smbm_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_rdata
);
  logic [31:0] str_q;
  logic [31:0] str_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // length of the current stretch, too long for a repetition
  always_comb begin
    str_d = scl_oe ? str_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk) begin
    str_q <= sys_rst ? 32'h0 : str_d;
  end
  property p_we_range;
    mem_we |-> mem_addr <= 16'h00DF || (mem_addr >= 16'hF800 && mem_addr <= 16'hFBFF);
  endproperty
  property p_we_erased;
    mem_we && mem_addr[15] |-> mem_rdata == 8'hFF;
  endproperty
  property p_ptr_step;
    mem_we |=> mem_addr == $past(mem_addr) + 16'h1;
  endproperty
  property p_we_pulse;
    mem_we |=> !mem_we [*8];
  endproperty
  property p_ee_stretch;
    mem_we && mem_addr[15] |-> ##[1:40] scl_oe;
  endproperty
  property p_ram_free;
    mem_we && !mem_addr[15] |=> !scl_oe [*8];
  endproperty
  property p_str_len;
    str_q <= PROG_CYCLES;
  endproperty
  // sda may move only while scl is low, else it reads as start or stop
  property p_sda_move;
    $changed(sda_oe) |-> !scl_i && !$past(scl_i);
  endproperty
  a_we_range: assert property (p_we_range) else $error("write outside memory");
  a_we_erased: assert property (p_we_erased) else $error("eeprom overwrite");
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse too close");
  a_ee_stretch: assert property (p_ee_stretch) else $error("no stretch");
  a_ram_free: assert property (p_ram_free) else $error("ram write stretched");
  a_str_len: assert property (p_str_len) else $error("stretch too long");
  a_sda_move: assert property (p_sda_move) else $error("sda moved with scl high");
  c_ee_wr: cover property (mem_we && mem_addr[15]);
  c_ram_wr: cover property (mem_we && !mem_addr[15]);
  c_str: cover property ($rose(scl_oe));
endmodule
bind smbm_slave smbm_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .mem_addr(mem_addr), .mem_we(mem_we), .mem_rdata(mem_rdata)
);

//--- smbm_crc8.sv
`timescale 1ns/1ps
`include "smbm_defines.svh"

module smbm_crc8 (
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] crc_out
);
  logic [7:0] c;

  // msb first, one bit per step
  always_comb begin
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `SMBM_CRC_POLY) : (c << 1); // RULE_16
    end
    crc_out = c;
  end
endmodule

//--- smbm_defines.svh
`ifndef SMBM_DEFINES_SVH
`define SMBM_DEFINES_SVH

`define SMBM_CMD_BLK_WR     8'hFC
`define SMBM_CMD_BLK_RD     8'hFD
`define SMBM_RAM_TOP        8'hDF
`define SMBM_EE_HI_FIRST    8'hF8
`define SMBM_EE_HI_LAST     8'hFB
`define SMBM_EE_BASE        16'hF800
`define SMBM_EE_TOP         16'hFBFF
`define SMBM_BLK_MAX        8'h20
`define SMBM_RD_COUNT       8'h20
`define SMBM_ERASED         8'hFF
`define SMBM_IDLE_BYTE      8'hFF
`define SMBM_CRC_POLY       8'h07
`define SMBM_CRC_INIT       8'h00
`define SMBM_PTR_RST        16'h0000
`define SMBM_T_PROG_NS      250000
`define SMBM_CLK_PERIOD_NS  25
`define SMBM_PROG_CYCLES    ((`SMBM_T_PROG_NS + `SMBM_CLK_PERIOD_NS - 1) / `SMBM_CLK_PERIOD_NS)

`endif

//--- smbm_host.sv
`timescale 1ns/1ps
module smbm_host (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  initial begin
    scl_oe = 1'h0;
    sda_oe = 1'h0;
  end
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    scl_oe = 1'h1;
    #50 sda_oe = ~b;
    #50 scl_oe = 1'h0;
    // bounded, a stuck stretch must not hang the run
    while (scl !== 1'h1 && n < 400) begin
      #25 n++;
    end
    #50 r = sda;
    #50;
  endtask
  task automatic start();
    scl_oe = 1'h1;
    #50 sda_oe = 1'h0;
    #50 scl_oe = 1'h0;
    #100 sda_oe = 1'h1;
    #100;
  endtask
  task automatic stop();
    scl_oe = 1'h1;
    #50 sda_oe = 1'h1;
    #50 scl_oe = 1'h0;
    #100 sda_oe = 1'h0;
    #100;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'h1, r);
      d = {d[6:0], r};
    end
    bit_io(~ack, r);
  endtask
endmodule

//--- smbm_pkg.sv
package smbm_pkg;
  typedef enum logic [2:0] {
    SMBM_IDLE,
    SMBM_RX,
    SMBM_ACK,
    SMBM_TX,
    SMBM_TXACK,
    SMBM_WAIT
  } smbm_state_t;
endpackage

//--- smbm_slave.sv
`timescale 1ns/1ps
`include "smbm_defines.svh"

// How it works
// RULE_01: block write command 0xFC is acknowledged
// RULE_02: master sends count then count data
// RULE_03: every block write data byte acknowledged
// RULE_04: master sets start location beforehand
// RULE_05: master keeps eeprom writes below top
// RULE_06: master erases both spanned pages
// RULE_07: eeprom block writes cross pages freely
// RULE_08: hold scl low while byte programs
// RULE_09: receive byte returns selected location
// RULE_10: master nacks received byte, then stops
// RULE_11: block read command 0xFD is acknowledged
// RULE_12: repeated start, read address, device acks
// RULE_13: block read sends 0x20 then 32 bytes
// RULE_14: master acks count and data, stops
// RULE_15: optional pec byte after writes, reads; slave sends it only after block reads
// RULE_16: pec is crc-8, poly x8+x2+x+1
// RULE_17: master checks pec, nacks, retries
// RULE_18: first byte is address plus direction
// RULE_19: ram 0x00-0xDF, eeprom 0xF800-0xFBFF
// RULE_20: program only erased eeprom locations
// RULE_21: eeprom select is high then low byte
// RULE_22: pointer advances per block byte; block writes advance it only for the bytes they write
module smbm_slave #(
  parameter int unsigned PROG_CYCLES = `SMBM_PROG_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [6:0]  dev_addr,
  input  wire logic        pec_en,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  input  wire logic [7:0]  mem_rdata,
  output logic             prog_busy
);
  logic                    scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  smbm_pkg::smbm_state_t   st_q, st_d;
  logic [3:0]              bitc_q, bitc_d;
  logic [7:0]              sh_q, sh_d, cmd_q, cmd_d, cnt_q, cnt_d, crc_q, crc_d;
  logic [6:0]              idx_q, idx_d;
  logic [5:0]              txn_q, txn_d;
  logic [15:0]             ptr_q, ptr_d;
  logic                    rw_q, rw_d, rdblk_q, rdblk_d, ack_q, ack_d, incp_q, incp_d;
  logic                    we_q, we_d, sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic [7:0]              wd_q, wd_d;
  logic [13:0]             prog_q, prog_d;
  logic                    rise, fall, start, stop, ram_hit, ee_hit;
  logic [7:0]              b, txb, crc_seed, crc_data, crc_nxt;

  assign rise  = scl_s_q & ~scl_p_q;
  assign fall  = ~scl_s_q & scl_p_q;
  assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign b     = {sh_q[6:0], sda_s_q};
  assign ram_hit = (ptr_q[15:8] == 8'h00) && (ptr_q[7:0] <= `SMBM_RAM_TOP); // RULE_19
  assign ee_hit  = (ptr_q >= `SMBM_EE_BASE) && (ptr_q <= `SMBM_EE_TOP); // RULE_19

  smbm_crc8 u_crc (
    .crc_in  (crc_seed),
    .data_in (crc_data),
    .crc_out (crc_nxt)
  );

  // next byte to send; pec only when enabled, else bus idles high
  always_comb begin
    txb = `SMBM_IDLE_BYTE;
    if (rdblk_q) begin
      if (txn_q == 6'h00) begin
        txb = `SMBM_RD_COUNT; // RULE_13
      end else if (txn_q <= 6'h20) begin
        txb = mem_rdata; // RULE_13
      end else if (txn_q == 6'h21 && pec_en) begin
        txb = crc_q; // RULE_15
      end
    end else if (txn_q == 6'h00) begin
      txb = mem_rdata; // RULE_09
    end
  end

  always_comb begin
    st_d     = st_q;
    bitc_d   = bitc_q;
    {sh_d, cmd_d, cnt_d, crc_d} = {sh_q, cmd_q, cnt_q, crc_q};
    idx_d    = idx_q;
    txn_d    = txn_q;
    ptr_d    = ptr_q;
    {rw_d, rdblk_d, ack_d, incp_d} = {rw_q, rdblk_q, ack_q, incp_q};
    we_d     = 1'b0;
    wd_d     = wd_q;
    sda_oe_d = sda_oe_q;
    crc_seed = crc_q;
    crc_data = b;
    prog_d   = (prog_q != 14'h0000) ? prog_q - 14'h0001 : prog_q;
    // pointer moves only after the write has used it
    if (we_q && incp_q) begin
      ptr_d = ptr_q + 16'h0001; // RULE_22 RULE_07
    end
    case (st_q)
      smbm_pkg::SMBM_IDLE, smbm_pkg::SMBM_WAIT: begin
      end
      smbm_pkg::SMBM_RX: begin
        if (rise && bitc_q < 4'h8) begin
          sh_d   = b;
          bitc_d = bitc_q + 4'h1;
          if (bitc_q == 4'h7) begin
            ack_d  = 1'b1;
            incp_d = 1'b0;
            crc_d  = crc_nxt;
            if (idx_q != 7'h7F) begin
              idx_d = idx_q + 7'h01;
            end
            if (idx_q == 7'h00) begin
              ack_d = (b[7:1] == dev_addr); // RULE_18
              rw_d  = b[0]; // RULE_18
              txn_d = 6'h00;
              if (!rdblk_q) begin
                crc_seed = `SMBM_CRC_INIT;
              end
              if (!b[0]) begin
                rdblk_d = 1'b0;
              end
            end else if (idx_q == 7'h01) begin
              cmd_d   = b;
              rdblk_d = (b == `SMBM_CMD_BLK_RD); // RULE_11
              if (b <= `SMBM_RAM_TOP) begin
                ptr_d = {8'h00, b}; // RULE_04
              end else if (b >= `SMBM_EE_HI_FIRST && b <= `SMBM_EE_HI_LAST) begin
                ptr_d = {b, ptr_q[7:0]}; // RULE_21
              end
            end else if (cmd_q == `SMBM_CMD_BLK_WR) begin // RULE_01
              if (idx_q == 7'h02) begin
                cnt_d = b; // RULE_02
                ack_d = (b <= `SMBM_BLK_MAX);
              end else if ({1'b0, idx_q} < cnt_q + 8'h03) begin
                wd_d   = b;
                incp_d = 1'b1;
                we_d   = ram_hit || (ee_hit && mem_rdata == `SMBM_ERASED); // RULE_20
                if (ee_hit && mem_rdata == `SMBM_ERASED) begin
                  prog_d = PROG_CYCLES[13:0]; // RULE_08
                end
              end
              // trailing pec byte is acked and not stored
            end else if (cmd_q <= `SMBM_RAM_TOP && idx_q == 7'h02) begin
              wd_d = b;
              we_d = ram_hit;
            end else if (cmd_q >= `SMBM_EE_HI_FIRST && cmd_q <= `SMBM_EE_HI_LAST) begin
              if (idx_q == 7'h02) begin
                ptr_d = {cmd_q, b}; // RULE_21
              end else if (idx_q == 7'h03) begin
                wd_d = b;
                we_d = ee_hit && mem_rdata == `SMBM_ERASED; // RULE_20
                if (we_d) begin
                  prog_d = PROG_CYCLES[13:0]; // RULE_08
                end
              end
            end
          end
        end else if (fall && bitc_q == 4'h8) begin
          sda_oe_d = ack_q; // RULE_03
          st_d     = smbm_pkg::SMBM_ACK;
        end
      end
      smbm_pkg::SMBM_ACK: begin
        if (fall) begin
          sda_oe_d = 1'b0;
          bitc_d   = 4'h0;
          if (!ack_q) begin
            st_d = smbm_pkg::SMBM_WAIT;
          end else if (idx_q == 7'h01 && rw_q) begin
            crc_seed = crc_q;
            crc_data = txb;
            crc_d    = crc_nxt;
            sda_oe_d = ~txb[7];
            sh_d     = {txb[6:0], 1'b0};
            txn_d    = txn_q + 6'h01;
            if (rdblk_q && txn_q != 6'h00 && txn_q <= 6'h20) begin
              ptr_d = ptr_q + 16'h0001; // RULE_22
            end
            st_d = smbm_pkg::SMBM_TX;
          end else begin
            st_d = smbm_pkg::SMBM_RX;
          end
        end
      end
      smbm_pkg::SMBM_TX: begin
        if (rise) begin
          bitc_d = bitc_q + 4'h1;
        end else if (fall) begin
          if (bitc_q == 4'h8) begin
            sda_oe_d = 1'b0;
            st_d     = smbm_pkg::SMBM_TXACK;
          end else begin
            sda_oe_d = ~sh_q[7];
            sh_d     = {sh_q[6:0], 1'b0};
          end
        end
      end
      smbm_pkg::SMBM_TXACK: begin
        if (rise) begin
          ack_d = ~sda_s_q;
        end else if (fall) begin
          bitc_d = 4'h0;
          if (!ack_q) begin
            st_d = smbm_pkg::SMBM_WAIT;
          end else begin
            crc_data = txb;
            crc_d    = crc_nxt;
            sda_oe_d = ~txb[7];
            sh_d     = {txb[6:0], 1'b0};
            if (txn_q != 6'h3F) begin
              txn_d = txn_q + 6'h01;
            end
            if (rdblk_q && txn_q != 6'h00 && txn_q <= 6'h20) begin
              ptr_d = ptr_q + 16'h0001; // RULE_22
            end
            st_d = smbm_pkg::SMBM_TX;
          end
        end
      end
      default: begin
        st_d = smbm_pkg::SMBM_IDLE;
      end
    endcase
    // bus conditions override the byte engine
    if (start) begin
      st_d     = smbm_pkg::SMBM_RX;
      bitc_d   = 4'h0;
      idx_d    = 7'h00;
      sda_oe_d = 1'b0;
    end else if (stop) begin
      st_d     = smbm_pkg::SMBM_IDLE;
      rdblk_d  = 1'b0;
      sda_oe_d = 1'b0;
    end
    // stretch only from a low scl, never pull it down mid-high
    scl_oe_d = (prog_d != 14'h0000) && (scl_oe_q || fall || !scl_s_q); // RULE_08
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3F;
      st_q     <= smbm_pkg::SMBM_IDLE;
      bitc_q   <= 4'h0;
      sh_q     <= 8'h00;
      cmd_q    <= 8'h00;
      cnt_q    <= 8'h00;
      crc_q    <= `SMBM_CRC_INIT;
      idx_q    <= 7'h00;
      txn_q    <= 6'h00;
      ptr_q    <= `SMBM_PTR_RST;
      {rw_q, rdblk_q, ack_q, incp_q, we_q, sda_oe_q, scl_oe_q} <= 7'h00;
      wd_q     <= 8'h00;
      prog_q   <= 14'h0000;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      st_q     <= st_d;
      bitc_q   <= bitc_d;
      sh_q     <= sh_d;
      cmd_q    <= cmd_d;
      cnt_q    <= cnt_d;
      crc_q    <= crc_d;
      idx_q    <= idx_d;
      txn_q    <= txn_d;
      ptr_q    <= ptr_d;
      {rw_q, rdblk_q, ack_q, incp_q} <= {rw_d, rdblk_d, ack_d, incp_d};
      {we_q, sda_oe_q, scl_oe_q} <= {we_d, sda_oe_d, scl_oe_d};
      wd_q     <= wd_d;
      prog_q   <= prog_d;
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge core_clk) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  assign scl_oe    = scl_oe_q;
  assign sda_oe    = sda_oe_q;
  assign mem_addr  = ptr_q;
  assign mem_wdata = wd_q;
  assign mem_we    = we_q;
  assign prog_busy = scl_oe_q;
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t value differs", $time); end end
module testbench;
  localparam int unsigned PROG = 20;
  logic        core_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        pec_en = 1'h0;
  logic [6:0]  dev_addr = 7'h00;
  logic        scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, mem_we, prog_busy;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, crc, b;
  logic [7:0]  mem [0:65535];
  logic [7:0]  exp_m [0:65535];
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          busy_cnt = 0;
  wire         scl = ~(scl_oe & ~scl_o | m_scl);
  wire         sda = ~(sda_oe & ~sda_o | m_sda);
  always #12.5 core_clk = ~core_clk;
  assign mem_rdata = mem[mem_addr];
  smbm_slave #(.PROG_CYCLES(PROG)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr(dev_addr), .pec_en(pec_en),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .prog_busy(prog_busy)
  );
  smbm_host u_host (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (prog_busy) busy_cnt <= busy_cnt + 1;
    if (cyc == 80000) begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
    return r;
  endfunction
  task automatic wr(input logic [7:0] d, input logic ex);
    logic a;
    u_host.wbyte(d, a);
    crc = crc8(crc, d);
    `CHK(a, ex)
  endtask
  task automatic rd(input logic ack, input logic [7:0] e);
    u_host.rbyte(ack, b);
    crc = crc8(crc, b);
    `CHK(b, e)
  endtask
  task automatic go(input logic rw);
    u_host.start();
    wr({dev_addr, rw}, 1'h1);
  endtask
  task automatic set_ptr(input logic [15:0] p);
    go(1'h0);
    if (p[15]) wr(p[15:8], 1'h1);
    wr(p[7:0], 1'h1);
    u_host.stop();
    crc = 8'h00;
  endtask
  task automatic blk_wr(input logic [15:0] p, input int n);
    int  bz;
    logic w;
    logic st;
    st = 1'h0;
    set_ptr(p);
    bz = busy_cnt;
    go(1'h0);
    wr(8'hFC, 1'h1);
    wr(8'(n), 1'h1);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      w = !p[15] || exp_m[p + i] === 8'hFF;
      if (w) exp_m[p + i] = b;
      st = st | (w & p[15]);
      wr(b, 1'h1);
    end
    if (pec_en) wr(crc, 1'h1);
    u_host.stop();
    `CHK(busy_cnt > bz, st)
  endtask
  task automatic blk_rd(input logic [15:0] p);
    set_ptr(p);
    go(1'h0);
    wr(8'hFD, 1'h1);
    go(1'h1);
    rd(1'h1, 8'h20);
    for (int i = 0; i < 32; i++) rd(1'h1, exp_m[p + i]);
    if (pec_en) rd(1'h0, crc);
    u_host.stop();
  endtask
  task automatic recv(input logic [15:0] p);
    set_ptr(p);
    go(1'h1);
    rd(1'h0, exp_m[p]);
    u_host.stop();
  endtask
  initial begin
    logic [15:0] p;
    // all eeprom pages start erased
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
      exp_m[i] = 8'hFF;
    end
    void'($urandom(32'hBC3843E5));
    dev_addr = 7'($urandom);
    repeat (10) @(negedge core_clk);
    sys_rst = 1'h0;
    repeat (4) @(negedge core_clk);
    u_host.start();
    wr({~dev_addr, 1'h0}, 1'h0);
    u_host.stop();
    for (int k = 0; k < 2; k++) begin
      p = 16'($urandom_range(0, 192));
      blk_wr(p, $urandom_range(1, 32));
      blk_rd(p);
      recv(p);
      @(negedge core_clk);
      pec_en = 1'h1;
    end
    blk_wr(16'hF81C, 8);
    blk_wr(16'hF81E, 2);
    blk_wr(16'hFBFC, 4);
    blk_rd(16'hF810);
    recv(16'hFBFF);
    end_of_test();
  end
endmodule
